/* File: core/utrc_defines.svh */
// Register offsets, field positions, reset values and counts of the serial core
`ifndef UTRC_DEFINES_SVH
`define UTRC_DEFINES_SVH

// Register offsets
`define UTRC_ADDR_DATA      3'h0
`define UTRC_ADDR_STATUS    3'h1
`define UTRC_ADDR_CTRL_B    3'h2
`define UTRC_ADDR_CTRL_C    3'h3
`define UTRC_ADDR_BAUD_LO   3'h4
`define UTRC_ADDR_BAUD_HI   3'h5

// Status register fields
`define UTRC_STA_RXC        7
`define UTRC_STA_TXC        6
`define UTRC_STA_TX_BUFFER_EMPTY_FLAG       5
`define UTRC_STA_U2X        1

// Control register B fields
`define UTRC_CB_TX_COMPLETE_IRQ_ENABLE       6
`define UTRC_CB_TX_BUFFER_EMPTY_IRQ_ENABLE       5
`define UTRC_CB_RECEIVER_ENABLE_BIT        4
`define UTRC_CB_TRANSMITTER_ENABLE_BIT        3
`define UTRC_CB_SZ2         2
`define UTRC_CB_RX_NINTH_BIT        1
`define UTRC_CB_TX_NINTH_BIT        0

// Control register C fields
`define UTRC_CC_SYNC        6
`define UTRC_CC_PEN         5
`define UTRC_CC_PODD        4
`define UTRC_CC_STOP2       3
`define UTRC_CC_SZ_HI       2
`define UTRC_CC_SZ_LO       1
`define UTRC_CC_POL         0

// Reset values
`define UTRC_RST_CTRL_B     8'h00
`define UTRC_RST_CTRL_C     8'h06
`define UTRC_RST_BAUD       12'h000

// Oversampling counts, minus one, and the nine-bit character size code
`define UTRC_OS_NORMAL      4'hf
`define UTRC_OS_DOUBLE      4'h7
`define UTRC_SIZE_NINE      3'h7

`endif

/* File: core/utrc_pkg.sv */
// Types shared by the serial transmit and receive core
`default_nettype none

package utrc_pkg;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } utrc_bus_req_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_BITS
    } utrc_rx_state_t;

endpackage : utrc_pkg

`default_nettype wire

/* File: core/utrc_core.sv */
// Serial transmitter and receiver with register port, parity and nine-bit characters
//
// Notes on behaviour
// - Transmitter enable hands the serial output pin to the transmitter.
// - Synchronous mode clocks transmission from the synchronous clock pin.
// - Writing the data register places the character in the transmit buffer.
// - Buffer moves to shifter when shifter idle or right after last stop bit.
// - A loaded shifter sends one frame at divisor/double-speed or external clock rate.
// - Unused upper data bits are ignored for characters under eight bits.
// - Ninth transmit bit written first is sent as data bit eight.
// - Buffer-empty flag reads one when buffer empty, zero while data waits.
// - Writing the data register clears the buffer-empty flag.
// - Buffer-empty request stays asserted while enabled, flag set, globally enabled.
// - Transmit-complete sets when frame finished and buffer holds nothing new.
// - Transmit-complete clears on interrupt service or on writing one.
// - Transmit-complete request raised when flag sets, if enabled and global.
// - Parity enable inserts parity after last data bit, before first stop.
// - Transmitter disable waits until shifter and buffer empty, then releases pin.
// - Receiver enable hands the serial input pin to the receiver.
// - Synchronous mode receives on the synchronous clock pin.
// - Reception starts on a valid start bit; bits sampled up to stop.
// - A second stop bit is ignored by the receiver.
// - After first stop bit the frame moves into the receive buffer.
// - Unused upper bits read as zero for short characters.
// - Frame: low start, data LSB first, optional parity, high stops; idle high.
// - Parity is XOR of data bits, inverted for odd parity.
// - Receive-complete flag is one while unread data sits in the buffer.
// - Received ninth bit shows in control register B before data read.
//
// Implementation choices: the register addresses and strobed register access.
`default_nettype none
`include "utrc_defines.svh"

module utrc_core (
    // Clock, reset, enable
    input  wire logic                   clk_in,
    input  wire logic                   srst_in,
    input  wire logic                   ce_in,
    // Register port
    input  wire utrc_pkg::utrc_bus_req_t bus_in,
    output logic [7:0]                  rdata_out,
    // Serial pins
    input  wire logic                   rxd_in,
    input  wire logic                   xck_in,
    output logic                        txd_out,
    output logic                        txd_oe_out,
    output logic                        rxd_own_out,
    // Interrupt requests
    input  wire logic                   global_irq_enable_in,
    input  wire logic                   txc_irq_ack_in,
    output logic                        tx_buffer_empty_flag_irq_out,
    output logic                        txc_irq_out
);
    import utrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode

    logic [7:0]     ctrl_b;
    logic [7:0]     ctrl_c;
    logic           double_speed;
    logic [11:0]    baud_div;
    logic           tx_complete_flag;
    logic [8:0]     tx_buf;
    logic           tx_buf_full;
    logic           tx_busy;
    logic           tx_active;
    logic [12:0]    tx_frame;
    logic [3:0]     tx_left;
    logic [3:0]     tx_phase;
    logic [7:0]     rx_buf;
    logic           rx_ninth;
    logic           rx_full;
    utrc_rx_state_t rx_state;
    logic [3:0]     rx_phase;
    logic [3:0]     rx_idx;
    logic [8:0]     rx_word;
    logic [11:0]    baud_cnt;
    logic           baud_tick;
    logic           rxd_s1;
    logic           rxd_s2;
    logic           rx_prev;
    logic           xck_s1;
    logic           xck_s2;
    logic           xck_prev;

    logic           wr_data;
    logic           wr_status;
    logic           rd_data;
    logic           sync_mode;
    logic           par_en;
    logic           stop2;
    logic [3:0]     n_bits;
    logic [3:0]     os_max;
    logic           xck_rise;
    logic           xck_fall;
    logic           xck_change;
    logic           xck_sample;
    logic           tx_bit_tick;
    logic           frame_end;
    logic           load_now;
    logic           rx_sample;
    logic           rx_done;
    logic [3:0]     rx_total;

    assign wr_data   = bus_in.wr && bus_in.addr == `UTRC_ADDR_DATA;
    assign wr_status = bus_in.wr && bus_in.addr == `UTRC_ADDR_STATUS;
    assign rd_data   = bus_in.rd && bus_in.addr == `UTRC_ADDR_DATA;
    assign sync_mode = ctrl_c[`UTRC_CC_SYNC];
    assign par_en    = ctrl_c[`UTRC_CC_PEN];
    assign stop2     = ctrl_c[`UTRC_CC_STOP2];
    assign os_max    = double_speed ? `UTRC_OS_DOUBLE : `UTRC_OS_NORMAL;

    always_comb begin
        case ({ctrl_b[`UTRC_CB_SZ2], ctrl_c[`UTRC_CC_SZ_HI:`UTRC_CC_SZ_LO]})
            3'h0:            n_bits = 4'h5;
            3'h1:            n_bits = 4'h6;
            3'h2:            n_bits = 4'h7;
            `UTRC_SIZE_NINE: n_bits = 4'h9;
            default:         n_bits = 4'h8;
        endcase
    end

    // Control registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_b       <= `UTRC_RST_CTRL_B;
            ctrl_c       <= `UTRC_RST_CTRL_C;
            double_speed <= 1'b0;
            baud_div     <= `UTRC_RST_BAUD;
        end else if (ce_in && bus_in.wr) begin
            case (bus_in.addr)
                `UTRC_ADDR_STATUS:  double_speed <= bus_in.wdata[`UTRC_STA_U2X];
                `UTRC_ADDR_CTRL_B:  ctrl_b <= bus_in.wdata;
                `UTRC_ADDR_CTRL_C:  ctrl_c <= bus_in.wdata;
                `UTRC_ADDR_BAUD_LO: baud_div[7:0] <= bus_in.wdata;
                `UTRC_ADDR_BAUD_HI: baud_div[11:8] <= bus_in.wdata[3:0];
                default: ;
            endcase
        end
    end

    // Read port, data valid only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            rdata_out <= 8'h00;
            if (bus_in.rd) begin
                case (bus_in.addr)
                    `UTRC_ADDR_DATA:    rdata_out <= rx_buf;
                    `UTRC_ADDR_STATUS:  rdata_out <= {rx_full, tx_complete_flag,
                                                      !tx_buf_full, 3'h0,
                                                      double_speed, 1'b0};
                    `UTRC_ADDR_CTRL_B:  rdata_out <= {ctrl_b[7:2], rx_ninth,
                                                      ctrl_b[0]};
                    `UTRC_ADDR_CTRL_C:  rdata_out <= ctrl_c;
                    `UTRC_ADDR_BAUD_LO: rdata_out <= baud_div[7:0];
                    `UTRC_ADDR_BAUD_HI: rdata_out <= {4'h0, baud_div[11:8]};
                    default:            rdata_out <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and clock sources

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rxd_s1   <= 1'b1;
            rxd_s2   <= 1'b1;
            rx_prev  <= 1'b1;
            xck_s1   <= 1'b0;
            xck_s2   <= 1'b0;
            xck_prev <= 1'b0;
        end else if (ce_in) begin
            rxd_s1   <= rxd_in;
            rxd_s2   <= rxd_s1;
            rx_prev  <= rxd_s2;
            xck_s1   <= xck_in;
            xck_s2   <= xck_s1;
            xck_prev <= xck_s2;
        end
    end

    assign xck_rise   = xck_s2 && !xck_prev;
    assign xck_fall   = !xck_s2 && xck_prev;
    assign xck_change = ctrl_c[`UTRC_CC_POL] ? xck_fall : xck_rise;
    assign xck_sample = ctrl_c[`UTRC_CC_POL] ? xck_rise : xck_fall;

    // Baud divisor, reloaded at zero or on a low-byte write
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            baud_cnt  <= `UTRC_RST_BAUD;
            baud_tick <= 1'b0;
        end else if (ce_in) begin
            baud_tick <= 1'b0;
            if (bus_in.wr && bus_in.addr == `UTRC_ADDR_BAUD_LO) begin
                baud_cnt <= {baud_div[11:8], bus_in.wdata};
            end else if (baud_cnt == 12'h000) begin
                baud_cnt  <= baud_div;
                baud_tick <= 1'b1;
            end else begin
                baud_cnt <= baud_cnt - 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter

    function automatic logic [12:0] frame_bits(input logic [8:0] d, input logic [3:0] n,
                                               input logic pen, input logic podd);
        logic [12:0] f;
        logic        p;
        f    = 13'h1fff;
        f[0] = 1'b0;
        p    = podd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                f[i + 1] = d[i];
                p        = p ^ d[i];
            end
        end
        if (pen) begin
            f[n + 4'h1] = p;
        end
        return f;
    endfunction

    assign tx_bit_tick = sync_mode ? xck_change
                                   : (baud_tick && tx_phase == os_max);
    assign frame_end   = tx_busy && tx_bit_tick && tx_left == 4'h1;
    assign load_now    = tx_active && tx_buf_full && (!tx_busy || frame_end);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_phase <= 4'h0;
        end else if (ce_in) begin
            if (load_now && !tx_busy) begin
                tx_phase <= 4'h0;
            end else if (baud_tick) begin
                tx_phase <= (tx_phase == os_max) ? 4'h0 : tx_phase + 4'h1;
            end
        end
    end

    // Transmit buffer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_buf      <= 9'h000;
            tx_buf_full <= 1'b0;
        end else if (ce_in) begin
            if (wr_data) begin
                tx_buf      <= {ctrl_b[`UTRC_CB_TX_NINTH_BIT], bus_in.wdata};
                tx_buf_full <= 1'b1;
            end else if (load_now) begin
                tx_buf_full <= 1'b0;
            end
        end
    end

    // Shift register; an idle frame of all ones keeps the line high
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_busy  <= 1'b0;
            tx_frame <= 13'h1fff;
            tx_left  <= 4'h0;
        end else if (ce_in) begin
            if (load_now) begin
                tx_busy  <= 1'b1;
                tx_frame <= frame_bits(tx_buf, n_bits, par_en,
                                       ctrl_c[`UTRC_CC_PODD]);
                tx_left  <= n_bits + 4'h2 + {3'h0, par_en} + {3'h0, stop2};
            end else if (frame_end) begin
                tx_busy  <= 1'b0;
                tx_frame <= 13'h1fff;
            end else if (tx_busy && tx_bit_tick) begin
                tx_frame <= {1'b1, tx_frame[12:1]};
                tx_left  <= tx_left - 4'h1;
            end
        end
    end

    // Pin ownership outlives the enable bit until all data is out
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_active <= 1'b0;
        end else if (ce_in) begin
            if (ctrl_b[`UTRC_CB_TRANSMITTER_ENABLE_BIT]) begin
                tx_active <= 1'b1;
            end else if (!tx_busy && !tx_buf_full) begin
                tx_active <= 1'b0;
            end
        end
    end

    assign txd_out    = tx_frame[0];
    assign txd_oe_out = tx_active;

    // Transmit-complete flag, setting wins over clearing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_complete_flag <= 1'b0;
        end else if (ce_in) begin
            if (frame_end && !load_now) begin
                tx_complete_flag <= 1'b1;
            end else if (txc_irq_ack_in
                         || (wr_status && bus_in.wdata[`UTRC_STA_TXC])) begin
                tx_complete_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_buffer_empty_flag_irq_out <= 1'b0;
            txc_irq_out  <= 1'b0;
        end else if (ce_in) begin
            tx_buffer_empty_flag_irq_out <= global_irq_enable_in && ctrl_b[`UTRC_CB_TX_BUFFER_EMPTY_IRQ_ENABLE]
                            && !tx_buf_full;
            txc_irq_out  <= global_irq_enable_in && ctrl_b[`UTRC_CB_TX_COMPLETE_IRQ_ENABLE]
                            && tx_complete_flag && !txc_irq_ack_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver

    assign rx_sample = sync_mode ? xck_sample
                                 : (baud_tick && rx_phase == os_max);
    assign rx_total  = n_bits + 4'h1 + {3'h0, par_en};
    assign rx_done   = rx_state == RX_BITS && rx_sample && rx_idx == rx_total - 4'h1;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_state <= RX_IDLE;
            rx_phase <= 4'h0;
            rx_idx   <= 4'h0;
            rx_word  <= 9'h000;
        end else if (ce_in) begin
            if (!ctrl_b[`UTRC_CB_RECEIVER_ENABLE_BIT]) begin
                rx_state <= RX_IDLE;
            end else begin
                case (rx_state)
                    RX_IDLE: begin
                        rx_phase <= 4'h0;
                        rx_idx   <= 4'h0;
                        rx_word  <= 9'h000;
                        if (sync_mode ? (xck_sample && !rxd_s2)
                                      : (rx_prev && !rxd_s2)) begin
                            rx_state <= sync_mode ? RX_BITS : RX_START;
                        end
                    end
                    RX_START: begin
                        if (baud_tick) begin
                            if (rx_phase == {1'b0, os_max[3:1]}) begin
                                rx_phase <= 4'h0;
                                rx_state <= rxd_s2 ? RX_IDLE : RX_BITS;
                            end else begin
                                rx_phase <= rx_phase + 4'h1;
                            end
                        end
                    end
                    RX_BITS: begin
                        if (baud_tick) begin
                            rx_phase <= (rx_phase == os_max) ? 4'h0 : rx_phase + 4'h1;
                        end
                        if (rx_sample) begin
                            if (rx_idx < n_bits) begin
                                rx_word[rx_idx] <= rxd_s2;
                            end
                            if (rx_done) begin
                                rx_state <= RX_IDLE;
                            end else begin
                                rx_idx <= rx_idx + 4'h1;
                            end
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer, new frame wins over a read in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_buf   <= 8'h00;
            rx_ninth <= 1'b0;
            rx_full  <= 1'b0;
        end else if (ce_in) begin
            if (!ctrl_b[`UTRC_CB_RECEIVER_ENABLE_BIT]) begin
                rx_full <= 1'b0;
            end else if (rx_done) begin
                rx_buf   <= rx_word[7:0];
                rx_ninth <= rx_word[8];
                rx_full  <= 1'b1;
            end else if (rd_data) begin
                rx_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rxd_own_out <= 1'b0;
        end else if (ce_in) begin
            rxd_own_out <= ctrl_b[`UTRC_CB_RECEIVER_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence seq_load_idle;
        ce_in && load_now && !tx_busy;
    endsequence

    sequence seq_frame_done;
        ce_in && frame_end && !load_now;
    endsequence

    AST_TX_START_LOW: assert property (seq_load_idle |=> !txd_out && tx_busy)
        else $error("start bit not driven low after load");
    AST_TXD_IDLE_HIGH: assert property (!tx_busy |-> txd_out)
        else $error("line not high while idle");
    AST_TX_BUFFER_EMPTY_FLAG_CLEAR: assert property (ce_in && wr_data |=> tx_buf_full)
        else $error("buffer-empty not cleared by data write");
    AST_TXC_SET: assert property (seq_frame_done |=> tx_complete_flag && !tx_busy)
        else $error("transmit-complete not set at frame end");
    AST_TXC_W1C: assert property (ce_in && wr_status && bus_in.wdata[`UTRC_STA_TXC]
                                  && !frame_end |=> !tx_complete_flag)
        else $error("transmit-complete not cleared by write of one");
    AST_OE_WHILE_BUSY: assert property (tx_busy || tx_buf_full |-> txd_oe_out)
        else $error("pin released with data pending");
    AST_OE_RELEASE: assert property (ce_in && !ctrl_b[`UTRC_CB_TRANSMITTER_ENABLE_BIT] && !tx_busy
                                     && !tx_buf_full |=> !txd_oe_out)
        else $error("pin not released after disable");
    AST_TX_BUFFER_EMPTY_FLAG_IRQ: assert property (ce_in && global_irq_enable_in && ctrl_b[`UTRC_CB_TX_BUFFER_EMPTY_IRQ_ENABLE]
                                   && !tx_buf_full |=> tx_buffer_empty_flag_irq_out)
        else $error("buffer-empty request missing");
    AST_RXC_READ: assert property (ce_in && rd_data && !rx_done && ctrl_b[`UTRC_CB_RECEIVER_ENABLE_BIT]
                                   |=> !rx_full)
        else $error("receive-complete not cleared by read");
    AST_RX_MASK: assert property (rx_full && n_bits < 4'h8
                                  |-> (rx_buf >> n_bits) == 8'h00)
        else $error("upper receive bits not zero");

endmodule : utrc_core

`default_nettype wire

/* File: tb/utrc_peer.sv */
// Remote serial node: frame sender and frame collector on the line
`default_nettype none
module utrc_peer #(
    parameter int BIT_CLKS = 8
) (
    input  wire logic       clk_in,
    input  wire logic       line_in,
    input  wire logic [3:0] nbits_in,
    output logic            rxd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] got_q[$];
    logic [10:0] shift;
    initial rxd_out = 1'b1;
    ////////////////////////////////////////
    // Low start, bits LSB first, then line back high
    task automatic send(input logic [10:0] bits, input int n);
        rxd_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            rxd_out <= bits[i];
            repeat (BIT_CLKS) @(posedge clk_in);
        end
        rxd_out <= 1'b1;
    endtask
    // Mid-bit sampling after each falling edge
    always begin
        @(negedge line_in);
        shift = '1;
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        for (int i = 0; i < nbits_in; i++) begin
            repeat (BIT_CLKS) @(posedge clk_in);
            shift[i] = line_in;
        end
        got_q.push_back(shift);
    end
endmodule // utrc_peer
`default_nettype wire

/* File: tb/utrc_core_tb.sv */
// Self-checking bench for the serial core
`default_nettype none
`include "utrc_defines.svh"
module utrc_core_tb;
    import utrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  tx_c[4] = '{8'h24, 8'h34, 8'h00, 8'h06};
    localparam logic [7:0]  tx_d[4] = '{8'h83, 8'h05, 8'hcd, 8'h55};
    localparam logic [10:0] tx_f[4] = '{11'h703, 11'h785, 11'h7ed, 11'h755};
    localparam logic [3:0]  tx_n[4] = '{4'h9, 4'h9, 4'h6, 4'ha};
    localparam logic [7:0]  rx_c[3] = '{8'h0e, 8'h00, 8'h06};
    localparam logic [10:0] rx_b[3] = '{11'h396, 11'h03b, 11'h3a5};
    localparam int          rx_n[3] = '{10, 6, 10};
    localparam logic [7:0]  rx_d[3] = '{8'h96, 8'h1b, 8'ha5};
    logic          clk_in = 1'b0;
    logic          srst_in = 1'b1;
    utrc_bus_req_t bus = '0;
    logic          gie = 1'b1;
    logic          ack = 1'b0;
    logic          synchronous_clock_pin = 1'b0;
    logic [3:0]    nbits = 4'h9;
    logic [7:0]    rdata;
    logic [7:0]    v;
    logic          rxd, txd, txd_oe, rxd_own, tx_buffer_empty_flag_irq, txc_irq;
    int            failures = 0;
    int            n_compared = 0;
    int            cycles = 0;
    ////////////////////////////////////////
    utrc_core dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .bus_in(bus), .rdata_out(rdata),
        .rxd_in(rxd), .xck_in(synchronous_clock_pin), .txd_out(txd), .txd_oe_out(txd_oe),
        .rxd_own_out(rxd_own), .global_irq_enable_in(gie), .txc_irq_ack_in(ack),
        .tx_buffer_empty_flag_irq_out(tx_buffer_empty_flag_irq), .txc_irq_out(txc_irq));
    // Released line idles high
    utrc_peer peer_u (.clk_in(clk_in), .line_in(txd_oe ? txd : 1'b1), .nbits_in(nbits),
        .rxd_out(rxd));
    always #5 clk_in = ~clk_in;
    // Synchronous clock, one bit per eight system clocks, edges off the system edge
    always #40 synchronous_clock_pin = ~synchronous_clock_pin;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    ////////////////////////////////////////
    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: saw %h, expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in);
        bus <= '0;
        #1 d = rdata;
        @(posedge clk_in);
    endtask
    task automatic expect_rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                             input string msg);
        rd(a, v);
        check(v & m, e, msg);
    endtask
    task automatic wait_flag(input logic [7:0] m);
        v = 8'h00;
        for (int i = 0; i < 300 && (v & m) !== m; i++)
            rd(`UTRC_ADDR_STATUS, v);
        check(v & m, m, "status flag wait");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        #1 check(txd_oe, 1'b0, "pin free at reset");
        check(tx_buffer_empty_flag_irq, 1'b0, "no request at reset");
        expect_rd(`UTRC_ADDR_STATUS, 8'hff, 8'h20, "status at reset");
        expect_rd(`UTRC_ADDR_CTRL_C, 8'hff, 8'h06, "format at reset");
        expect_rd(3'h6, 8'hff, 8'h00, "unmapped read");
        wr(`UTRC_ADDR_BAUD_LO, 8'h00);
        wr(`UTRC_ADDR_STATUS, 8'h02);
        wr(`UTRC_ADDR_CTRL_B, 8'h58);
        #1 check(txd_oe, 1'b1, "tx owns pin");
        check(rxd_own, 1'b1, "rx owns pin");
        $display("test setup done");
        wr(`UTRC_ADDR_DATA, 8'ha5);
        wr(`UTRC_ADDR_DATA, 8'h3c);
        expect_rd(`UTRC_ADDR_STATUS, 8'h60, 8'h00, "buffer full");
        wait_flag(8'h40);
        check(peer_u.got_q.pop_front(), 11'h7a5, "first frame");
        check(peer_u.got_q.pop_front(), 11'h73c, "second frame");
        expect_rd(`UTRC_ADDR_STATUS, 8'h20, 8'h20, "buffer empty");
        check(txc_irq, 1'b1, "txc request");
        ack <= 1'b1;
        @(posedge clk_in);
        ack <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check(txc_irq, 1'b0, "txc request dropped");
        expect_rd(`UTRC_ADDR_STATUS, 8'h40, 8'h00, "txc cleared by service");
        wr(`UTRC_ADDR_CTRL_B, 8'h38);
        @(posedge clk_in);
        #1 check(tx_buffer_empty_flag_irq, 1'b1, "empty request");
        gie <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check(tx_buffer_empty_flag_irq, 1'b0, "empty request masked");
        $display("test transmit flags done");
        for (int i = 0; i < 4; i++) begin
            wr(`UTRC_ADDR_CTRL_C, tx_c[i]);
            wr(`UTRC_ADDR_CTRL_B, (i == 3) ? 8'h1d : 8'h18);
            nbits <= tx_n[i];
            wr(`UTRC_ADDR_DATA, tx_d[i]);
            wait_flag(8'h40);
            check(peer_u.got_q.pop_front(), tx_f[i], "tx frame");
            wr(`UTRC_ADDR_STATUS, 8'h42);
            expect_rd(`UTRC_ADDR_STATUS, 8'h40, 8'h00, "txc write clear");
        end
        $display("test transmit formats done");
        for (int i = 0; i < 3; i++) begin
            wr(`UTRC_ADDR_CTRL_C, rx_c[i]);
            wr(`UTRC_ADDR_CTRL_B, (i == 2) ? 8'h1c : 8'h18);
            peer_u.send(rx_b[i], rx_n[i]);
            wait_flag(8'h80);
            if (i == 2)
                expect_rd(`UTRC_ADDR_CTRL_B, 8'h02, 8'h02, "rx ninth");
            expect_rd(`UTRC_ADDR_DATA, 8'hff, rx_d[i], "rx data");
            expect_rd(`UTRC_ADDR_STATUS, 8'h80, 8'h00, "rx flag after read");
        end
        $display("test receive formats done");
        wr(`UTRC_ADDR_CTRL_C, 8'h46);
        wr(`UTRC_ADDR_CTRL_B, 8'h18);
        nbits <= 4'h9;
        wr(`UTRC_ADDR_DATA, 8'h3c);
        wait_flag(8'h40);
        check(peer_u.got_q.pop_front(), 11'h73c, "sync frame");
        wr(`UTRC_ADDR_STATUS, 8'h42);
        $display("test synchronous transmit done");
        wr(`UTRC_ADDR_CTRL_C, 8'h06);
        nbits <= 4'h9;
        wr(`UTRC_ADDR_DATA, 8'h5a);
        wr(`UTRC_ADDR_CTRL_B, 8'h10);
        #1 check(txd_oe, 1'b1, "pin held in frame");
        for (int i = 0; i < 200 && txd_oe !== 1'b0; i++) begin
            @(posedge clk_in);
            #1;
        end
        check(txd_oe, 1'b0, "pin released");
        check(peer_u.got_q.pop_front(), 11'h75a, "frame before release");
        $display("test transmit disable done");
        conclude();
    end
endmodule // utrc_core_tb
`default_nettype wire
